//--- itb_timer.sv
// Interval / time-base timer with divided clock output and standby bit.
// Assumes an Avalon-MM master on CORE_CLK and a system controller that
// reports the power mode on POWER_MODE.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Time-base select 0 runs counter as 8-bit interval timer counting up
// R2 - Reset clears counter and time-base select; counting starts at once
// R3 - Interval mode counts one of eight system prescaler taps by clk select
// R4 - Count clock at all ones sets overflow flag, in both modes
// R5 - Interrupt output raised only while overflow enable is 1
// R6 - Counter wraps to zero and continues; overflow every 256 clocks
// R7 - Time-base select 1 counts watch prescaler outputs instead
// R8 - Time-base mode picks one of four overflow periods by two bits
// R9 - Time-base mode with clear bit set clears counter and watch prescaler
// R10 - Port mode enable drives clock on output pin, one of eight sources
// R11 - System clock /32,/16,/8,/4 output only in active and sleep
// R12 - Sub-clock /32,/16,/8,/4 output in active, sleep and subactive
// R13 - Standby bit 1 holds timer in standby; 0 after reset runs it
// R14 - Reserved top standby bit reads 0, writes ignored
// R15 - Overflow flag stays set until cleared; later overflow keeps it set
// R16 - Output codes 0-3 system /32../4, codes 4-7 sub-clock /32../4
module itb_timer
   import itb_pkg::*;
#(
   parameter int SUB_DIVIDE = itb_pkg::SUB_DIV
)(
   input  wire logic              CORE_CLK,
   input  wire logic              RESET,
   input  wire logic [5:0]        AVS_ADDRESS,
   input  wire logic              AVS_READ,
   input  wire logic              AVS_WRITE,
   input  wire logic [31:0]       AVS_WRITEDATA,
   input  wire logic [3:0]        AVS_BYTEENABLE,
   input  wire itb_pkg::itb_power_e POWER_MODE,
   output logic [31:0]            AVS_READDATA,
   output logic                   AVS_WAITREQUEST,
   output logic                   IRQ,
   output logic                   CLOCK_OUT_PIN,
   output logic                   CLOCK_OUT_OE_N
);
   import itb_pkg::*;

   // Divide taps: system prescaler bits for /8 .. /8192 interval clocks
   function automatic logic pick_sys(input logic [SPS_W-1:0] r, input logic [2:0] sel);
      logic [3:0] idx;
      begin
         // Codes 0..7 select /8192,/4096,/2048,/512,/256,/128,/32,/8
         unique case (sel)
            3'h0: idx = 4'hc;
            3'h1: idx = 4'hb;
            3'h2: idx = 4'ha;
            3'h3: idx = 4'h8;
            3'h4: idx = 4'h7;
            3'h5: idx = 4'h6;
            3'h6: idx = 4'h4;
            3'h7: idx = 4'h2;
         endcase
         pick_sys = r[idx];
      end
   endfunction

   logic [7:0]        count_reg, count_next;
   logic [7:0]        mode_reg, mode_next;
   logic              ovf_reg, ovf_next;
   logic              irq_en_reg, irq_en_next;
   logic              cko_en_reg, cko_en_next;
   logic              stby_reg, stby_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic              wait_reg, wait_next;
   logic              irq_reg, irq_next;
   logic              pin_reg, pin_next;
   logic              oe_n_reg, oe_n_next;

   logic [SPS_W-1:0]  sps_taps, sps_rise;
   logic [WPS_W-1:0]  wps_taps, wps_rise;
   logic              sub_tick;
   logic              run;
   logic              tb_clear;
   logic              count_tick;
   logic              overflow;
   logic              bus_hit;
   itb_ctrl_s         ctrl;

   assign ctrl = '{irq_en: irq_en_reg, out_sel: mode_reg[MODE_OUT_LSB +: 3],
                   tb_mode: mode_reg[MODE_TB_BIT], clk_sel: mode_reg[2:0]};
   assign run      = ~stby_reg;                                       // R13
   assign tb_clear = ctrl.tb_mode & ctrl.clk_sel[MODE_CLR_BIT];       // R9

   itb_subclk #(
      .DIV (SUB_DIVIDE)
   ) u_subclk (
      .clk  (CORE_CLK),
      .rst  (RESET),
      .tick (sub_tick)
   );

   // System prescaler counts every core cycle while the standby bit is 0
   itb_prescaler #(
      .WIDTH (SPS_W)
   ) u_sys_ps (
      .clk   (CORE_CLK),
      .rst   (RESET),
      .tick  (run),
      .clear (1'b0),
      .taps  (sps_taps),
      .rise  (sps_rise)
   );

   // Watch prescaler runs on the sub-clock
   itb_prescaler #(
      .WIDTH (WPS_W)
   ) u_watch_ps (
      .clk   (CORE_CLK),
      .rst   (RESET),
      .tick  (sub_tick & run),
      .clear (tb_clear),                                              // R9
      .taps  (wps_taps),
      .rise  (wps_rise)
   );

   // Count clock selection
   always_comb
   begin
      if (ctrl.tb_mode)                                               // R7
      begin
         // Periods 1 s, 0.5 s, 0.25 s, ~0.03 s at 256 counts
         unique case (ctrl.clk_sel[1:0])                              // R8
            2'h0: count_tick = wps_rise[6];
            2'h1: count_tick = wps_rise[5];
            2'h2: count_tick = wps_rise[4];
            2'h3: count_tick = wps_rise[1];
         endcase
         if (tb_clear)
            count_tick = 1'b0;
      end
      else
      begin
         count_tick = pick_sys(sps_rise, ctrl.clk_sel);               // R1 R3
      end
      count_tick = count_tick & run;
   end

   assign overflow = count_tick & (count_reg == 8'hff);               // R4

   // Counter and flag
   always_comb
   begin
      count_next = count_reg;
      if (tb_clear)
         count_next = COUNT_RST;                                      // R9
      else if (count_tick)
         count_next = count_reg + 8'h01;                              // R1 R6
      ovf_next = ovf_reg;
      if (AVS_WRITE & ~wait_reg & (AVS_ADDRESS == ADDR_IRQ_CLR)
          & AVS_BYTEENABLE[0] & AVS_WRITEDATA[STATUS_OVF])
         ovf_next = 1'b0;
      if (overflow)
         ovf_next = 1'b1;                                             // R4 R15
   end

   // Register bus: one wait cycle, then the access completes
   assign bus_hit = (AVS_READ | AVS_WRITE) & ~wait_reg;

   always_comb
   begin
      mode_next   = mode_reg;
      irq_en_next = irq_en_reg;
      cko_en_next = cko_en_reg;
      stby_next   = stby_reg;
      rdata_next  = rdata_reg;
      wait_next   = 1'b1;
      if ((AVS_READ | AVS_WRITE) & wait_reg)
         wait_next = 1'b0;
      if (bus_hit & AVS_WRITE & AVS_BYTEENABLE[0])
      begin
         unique case (AVS_ADDRESS)
            ADDR_MODE:     mode_next   = AVS_WRITEDATA[7:0];
            ADDR_IRQ_EN:   irq_en_next = AVS_WRITEDATA[STATUS_OVF];
            ADDR_PORTMODE: cko_en_next = AVS_WRITEDATA[PORT_CKO_BIT];
            ADDR_STANDBY:  stby_next   = AVS_WRITEDATA[STBY_BIT];     // R14
            default:       mode_next   = mode_reg;
         endcase
      end
      // Read data is registered on the edge that ends the wait cycle so that it already
      // stands when the master samples waitrequest low
      if (AVS_READ & wait_reg)
      begin
         unique case (AVS_ADDRESS)
            ADDR_MODE:     rdata_next = {24'h000000, mode_reg};
            ADDR_COUNT:    rdata_next = {24'h000000, count_reg};
            ADDR_STATUS:   rdata_next = {31'h00000000, ovf_reg};
            ADDR_IRQ_EN:   rdata_next = {31'h00000000, irq_en_reg};
            ADDR_PORTMODE: rdata_next = {31'h00000000, cko_en_reg};
            // Reserved bit 7 and unused bits read as zero
            ADDR_STANDBY:  rdata_next = {24'h000000, 8'({7'h00, stby_reg}) & STBY_WMASK}; // R14
            default:       rdata_next = READ_UNMAPPED;
         endcase
      end
   end

   // Interrupt and clock output pins
   always_comb
   begin
      irq_next  = ovf_next & irq_en_next;                             // R5
      oe_n_next = ~cko_en_next;                                       // R10
      pin_next  = 1'b0;
      // Codes 0-3 system /32../4, 4-7 sub-clock /32../4
      unique case (ctrl.out_sel)                                      // R16
         3'h0: pin_next = sps_taps[4];
         3'h1: pin_next = sps_taps[3];
         3'h2: pin_next = sps_taps[2];
         3'h3: pin_next = sps_taps[1];
         3'h4: pin_next = wps_taps[4];
         3'h5: pin_next = wps_taps[3];
         3'h6: pin_next = wps_taps[2];
         3'h7: pin_next = wps_taps[1];
      endcase
      // System clock sources stop outside active and sleep
      if (~ctrl.out_sel[2] & (POWER_MODE != ITB_ACTIVE) & (POWER_MODE != ITB_SLEEP))
         pin_next = 1'b0;                                             // R11
      // Sub-clock sources also stop in full standby
      if (ctrl.out_sel[2] & (POWER_MODE == ITB_STANDBY))
         pin_next = 1'b0;                                             // R12
      if (~cko_en_reg | stby_reg)
         pin_next = 1'b0;                                             // R10 R13
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         count_reg  <= COUNT_RST;                                     // R2
         mode_reg   <= MODE_RST;                                      // R2
         ovf_reg    <= 1'b0;
         irq_en_reg <= 1'b0;
         cko_en_reg <= 1'b0;
         stby_reg   <= 1'b0;                                          // R13
         rdata_reg  <= 32'h00000000;
         wait_reg   <= 1'b1;
         irq_reg    <= 1'b0;
         pin_reg    <= 1'b0;
         oe_n_reg   <= 1'b1;
      end
      else
      begin
         count_reg  <= count_next;
         mode_reg   <= mode_next;
         ovf_reg    <= ovf_next;
         irq_en_reg <= irq_en_next;
         cko_en_reg <= cko_en_next;
         stby_reg   <= stby_next;
         rdata_reg  <= rdata_next;
         wait_reg   <= wait_next;
         irq_reg    <= irq_next;
         pin_reg    <= pin_next;
         oe_n_reg   <= oe_n_next;
      end
   end

   assign AVS_READDATA    = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign IRQ             = irq_reg;
   assign CLOCK_OUT_PIN   = pin_reg;
   assign CLOCK_OUT_OE_N  = oe_n_reg;
endmodule // itb_timer

//--- itb_pkg.sv
// Package for the interval / time-base timer: register map, field layout,
// reset values, power-mode codes and the shared packed structs.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package itb_pkg;

   // Register byte addresses, one aligned word each
   localparam logic [5:0] ADDR_MODE     = 6'h00;
   localparam logic [5:0] ADDR_COUNT    = 6'h04;
   localparam logic [5:0] ADDR_STATUS   = 6'h08;
   localparam logic [5:0] ADDR_IRQ_CLR  = 6'h0c;
   localparam logic [5:0] ADDR_IRQ_EN   = 6'h10;
   localparam logic [5:0] ADDR_PORTMODE = 6'h14;
   localparam logic [5:0] ADDR_STANDBY  = 6'h18;

   localparam int CNT_W = 8;

   // Mode, status, port-mode and standby register field positions
   localparam int MODE_TB_BIT   = 3;
   localparam int MODE_CLR_BIT  = 2;
   localparam int MODE_SEL_LSB  = 0;
   localparam int MODE_OUT_LSB  = 5;
   localparam int STATUS_OVF    = 0;
   localparam int PORT_CKO_BIT  = 0;
   localparam int STBY_BIT      = 0;
   localparam int STBY_RSVD_BIT = 7;

   localparam logic [7:0] MODE_RST     = 8'h00;
   localparam logic [7:0] COUNT_RST    = 8'h00;
   localparam logic [7:0] STBY_WMASK   = 8'h7f;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // System prescaler width for the eight interval clocks
   localparam int SPS_W = 13;
   // Sub-clock: 32.768 kHz; modelled as an enable from the core clock
   localparam int  CORE_HZ   = 125_000_000;
   localparam int  SUB_HZ    = 32_768;
   localparam int  SUB_DIV   = CORE_HZ / SUB_HZ;
   localparam int  WPS_W     = 15;

   // Power-mode codes driven by the system controller
   typedef enum logic [1:0] {
      ITB_ACTIVE, ITB_SLEEP, ITB_SUBACTIVE, ITB_STANDBY
   } itb_power_e;

   typedef struct packed {
      logic       irq_en;
      logic [2:0] out_sel;
      logic       tb_mode;
      logic [2:0] clk_sel;
   } itb_ctrl_s;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [5:0] address;
      logic [31:0] writedata;
   } itb_bus_s;

endpackage : itb_pkg

//--- itb_prescaler.sv
// Counting prescaler: free-running divider whose bit outputs give
// rising-edge enable pulses. Assumes one clock, synchronous reset.
`timescale 1ns/1ps
module itb_prescaler #(
   parameter int WIDTH = 13
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             tick,
   input  wire logic             clear,
   output logic [WIDTH-1:0]      taps,
   output logic [WIDTH-1:0]      rise
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (clear)
         cnt_next = '0;
      else if (tick)
         cnt_next = cnt_reg + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

   assign taps = cnt_reg;
   // Bit k rises on the tick that carries into it
   assign rise = cnt_next & ~cnt_reg;
endmodule // itb_prescaler

//--- itb_subclk.sv
// Sub-clock enable generator: one-cycle pulse at the 32.768 kHz rate
// derived from the core clock, since the block has a single clock.
`timescale 1ns/1ps
module itb_subclk #(
   parameter int DIV = 3814
)(
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;

   always_comb
   begin
      tick_next = (cnt_reg == 16'(DIV - 1));
      cnt_next  = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_reg  <= 16'h0000;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule // itb_subclk

//--- itb_timer_asserts.sv
// Port-level checker for the interval / time-base timer.
// Assumes it is bound to itb_timer and sees only that module's ports.
`timescale 1ns/1ps
module itb_timer_asserts
   import itb_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   input wire logic [5:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire itb_power_e  POWER_MODE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        IRQ,
   input wire logic        CLOCK_OUT_PIN,
   input wire logic        CLOCK_OUT_OE_N
);
   logic       wr;
   logic       rd;
   logic       clr;
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   assign wr  = AVS_WRITE && AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   assign rd  = AVS_READ && AVS_WAITREQUEST;
   assign clr = wr && AVS_ADDRESS == ADDR_IRQ_CLR && AVS_WRITEDATA[0];
   // Shadow of irq enable, clock-out enable and top output-select bit
   always_comb
   begin
      sh_next = sh_reg;
      if (wr && AVS_ADDRESS == ADDR_IRQ_EN)
         sh_next[0] = AVS_WRITEDATA[0];
      if (wr && AVS_ADDRESS == ADDR_PORTMODE)
         sh_next[1] = AVS_WRITEDATA[0];
      if (wr && AVS_ADDRESS == ADDR_MODE)
         sh_next[2] = AVS_WRITEDATA[7];
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
         sh_reg <= 3'h0;
      else
         sh_reg <= sh_next;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sequence s_answer;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_answer)
      else $error("bus answer not one wait cycle");
   a_wait_idle: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest dropped without request");
   a_unmapped_zero: assert property (rd && AVS_ADDRESS > ADDR_STANDBY |=> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (rd |=> AVS_READDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_stby_rsvd: assert property (rd && AVS_ADDRESS == ADDR_STANDBY |=> !AVS_READDATA[7])
      else $error("reserved standby bit set");
   a_irq_off: assert property (!sh_reg[0] && $past(!sh_reg[0]) |-> !IRQ)
      else $error("irq high while disabled");
   a_irq_sticky: assert property (IRQ && sh_reg[0] && !clr && !$past(clr) |=> IRQ)
      else $error("irq dropped without clear");
   a_oe_follow: assert property ($past(sh_reg[1]) == sh_reg[1] |-> CLOCK_OUT_OE_N == !sh_reg[1])
      else $error("output enable wrong");
   a_pin_sub: assert property ((POWER_MODE == ITB_SUBACTIVE && !sh_reg[2]) [*4]
      |-> $stable(CLOCK_OUT_PIN)) else $error("system clock out in subactive");
   a_reset_vals: assert property (disable iff (1'b0) RESET |=> AVS_WAITREQUEST && !IRQ
      && CLOCK_OUT_OE_N && !CLOCK_OUT_PIN) else $error("reset outputs wrong");
endmodule // itb_timer_asserts

bind itb_timer itb_timer_asserts u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .POWER_MODE(POWER_MODE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .CLOCK_OUT_PIN(CLOCK_OUT_PIN),
   .CLOCK_OUT_OE_N(CLOCK_OUT_OE_N));

//--- test_interval_time_base_timer.sv
// Self-checking bench for the interval / time-base timer.
// Assumes itb_timer and its checker are compiled before this file.
`timescale 1ns/1ps
module test_interval_time_base_timer;
   import itb_pkg::*;
   localparam int SUBD = 4;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic [5:0]  addr  = 6'h00;
   logic        rd    = 1'b0;
   logic        wr    = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be    = 4'hf;
   itb_power_e  pmode = ITB_ACTIVE;
   logic [31:0] rdata;
   logic        wreq;
   logic        irq;
   logic        pin;
   logic        oe_n;
   logic [31:0] v;
   logic [31:0] w;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          t0;
   int          e;
   int          x;

   itb_timer #(.SUB_DIVIDE(SUBD)) i_dut (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .POWER_MODE(pmode), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .IRQ(irq),
      .CLOCK_OUT_PIN(pin), .CLOCK_OUT_OE_N(oe_n));

   initial forever #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic complete_run();
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // Request held until waitrequest is sampled low; bounded so a hang ends the run
   task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= we;
      rd    <= !we;
      do
      begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50)
      begin
         chk(32'h0, 32'h1);
         complete_run();
      end
   endtask
   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q & m, x);
   endtask
   task automatic wait_ovf();
      int k = 0;
      do
      begin
         xfer(1'b0, ADDR_STATUS, 32'h0, v);
         k++;
      end while (v[STATUS_OVF] !== 1'b1 && k < 3000);
      chk_rng(k, 1, 2999);
      if (k >= 3000)
         complete_run();
   endtask
   task automatic edges(output int n);
      logic p;
      n = 0;
      p = pin;
      repeat (256)
      begin
         @(posedge clk);
         if (pin === 1'b1 && p === 1'b0)
            n++;
         p = pin;
      end
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rchk(ADDR_MODE, 32'hffffffff, 32'h0);
      rchk(ADDR_STATUS, 32'hffffffff, 32'h0);
      rchk(ADDR_STANDBY, 32'hffffffff, 32'h0);
      rchk(6'h1c, 32'hffffffff, 32'h0);
      chk({31'h0, oe_n}, 32'h1);
      be <= 4'h0;
      wreg(ADDR_IRQ_EN, 32'h1);
      be <= 4'hf;
      rchk(ADDR_IRQ_EN, 32'hffffffff, 32'h0);
      wreg(ADDR_STANDBY, 32'hff);
      rchk(ADDR_STANDBY, 32'h81, 32'h01);
      wreg(ADDR_MODE, 32'h0b);
      xfer(1'b0, ADDR_COUNT, 32'h0, v);
      repeat (64) @(posedge clk);
      rchk(ADDR_COUNT, 32'hff, v);
      wreg(ADDR_STANDBY, 32'h0);
      repeat (64) @(posedge clk);
      xfer(1'b0, ADDR_COUNT, 32'h0, w);
      chk({31'h0, w !== v}, 32'h1);
      wreg(ADDR_MODE, 32'h0c);
      rchk(ADDR_COUNT, 32'hff, 32'h0);
      wreg(ADDR_MODE, 32'h0b);
      wreg(ADDR_IRQ_EN, 32'h1);
      wait_ovf();
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wreg(ADDR_IRQ_EN, 32'h0);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rchk(ADDR_STATUS, 32'h1, 32'h1);
      wreg(ADDR_IRQ_CLR, 32'h1);
      rchk(ADDR_STATUS, 32'h1, 32'h0);
      wreg(ADDR_MODE, 32'h07);
      wait_ovf();
      t0 = cyc;
      wreg(ADDR_IRQ_CLR, 32'h1);
      wait_ovf();
      chk_rng(cyc - t0, 2040, 2056);
      wreg(ADDR_MODE, 32'h06);
      wreg(ADDR_IRQ_CLR, 32'h1);
      wait_ovf();
      t0 = cyc;
      wreg(ADDR_IRQ_CLR, 32'h1);
      wait_ovf();
      chk_rng(cyc - t0, 8186, 8198);
      wreg(ADDR_PORTMODE, 32'h1);
      @(posedge clk);
      chk({31'h0, oe_n}, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
         wreg(ADDR_MODE, 32'(k) << 5);
         edges(e);
         x = (k < 4) ? 256 / (32 >> k) : 256 / (SUBD * (32 >> (k - 4)));
         chk_rng(e, x - 1, x + 1);
      end
      pmode <= ITB_SUBACTIVE;
      wreg(ADDR_MODE, 32'h60);
      edges(e);
      chk_rng(e, 0, 0);
      pmode <= ITB_SLEEP;
      edges(e);
      chk_rng(e, 62, 65);
      pmode <= ITB_SUBACTIVE;
      wreg(ADDR_MODE, 32'h80);
      edges(e);
      chk_rng(e, 1, 3);
      pmode <= ITB_STANDBY;
      @(posedge clk);
      edges(e);
      chk_rng(e, 0, 0);
      pmode <= ITB_ACTIVE;
      wreg(ADDR_PORTMODE, 32'h0);
      repeat (3) @(posedge clk);
      chk({30'h0, oe_n, pin}, 32'h2);
      complete_run();
   end
endmodule // test_interval_time_base_timer
